// ===== chan_misc_ctrl.sv
// control bytes for channels 1 to 4 with the per-channel override select
// assumes the serial host port decodes bytes into a one-cycle write strobe
`timescale 1ns/100ps
module chan_misc_ctrl (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // register port
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // decoder status, index 0 is channel 1
    input wire logic [3:0] video_loss,
    // per-channel controls to the decoders
    output logic [3:0] ntsc_kill_en,
    output logic [3:0] pal_kill_en,
    output logic [3:0] secam_kill_en,
    output logic [3:0] special_mode_en,
    output logic [3:0] blue_stretch_en,
    // substituted colour per channel: 0 none, 1 black, 2 blue
    output logic [7:0] colour_sub
);
    logic [7:0] shared_q;
    logic [7:0] override_reg_q;
    logic [7:0] chan_q [1:3];
    logic [7:0] eff [0:3];
    logic override_sel;
    logic [7:0] rdata_d;

    assign override_sel = override_reg_q[chan_misc_pkg::BIT_OVERRIDE];

    function automatic logic [1:0] colour_of(input logic [7:0] c, input logic loss);
        logic [1:0] r;
        r = chan_misc_pkg::COLOUR_NONE;
        // forcing wins whatever the loss state
        if (c[chan_misc_pkg::BIT_FORCE] || (c[chan_misc_pkg::BIT_LOSS] && loss)) begin
            r = c[chan_misc_pkg::BIT_COLOUR] ? chan_misc_pkg::COLOUR_BLUE
                                             : chan_misc_pkg::COLOUR_BLACK;
        end
        return r;
    endfunction : colour_of

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            shared_q <= chan_misc_pkg::RST_CTRL;
            override_reg_q <= chan_misc_pkg::RST_OVERRIDE_REG;
        end else if (reg_wr) begin
            if (reg_addr == chan_misc_pkg::OFS_SHARED) begin
                shared_q <= reg_wdata;
            end
            if (reg_addr == chan_misc_pkg::OFS_OVERRIDE) begin
                override_reg_q <= reg_wdata;
            end
        end
    end

    genvar g;
    generate
        for (g = 1; g <= 3; g++) begin : g_chan
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    chan_q[g] <= chan_misc_pkg::RST_CTRL;
                end else if (reg_wr && reg_addr == chan_misc_pkg::OFS_CHAN2 + 8'(g - 1)) begin
                    chan_q[g] <= reg_wdata;
                end
            end
            // shared byte governs all channels unless override is set
            assign eff[g] = override_sel ? chan_q[g] : shared_q;
        end
    endgenerate
    assign eff[0] = shared_q;

    always_comb begin
        unique case (reg_addr)
            chan_misc_pkg::OFS_SHARED: rdata_d = shared_q;
            chan_misc_pkg::OFS_OVERRIDE: rdata_d = override_reg_q;
            chan_misc_pkg::OFS_CHAN2: rdata_d = chan_q[1];
            chan_misc_pkg::OFS_CHAN3: rdata_d = chan_q[2];
            chan_misc_pkg::OFS_CHAN4: rdata_d = chan_q[3];
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= rdata_d;
        end
    end

    // outputs registered; two cycles after a write, one cycle after a loss change
    generate
        for (g = 0; g < 4; g++) begin : g_out
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    ntsc_kill_en[g] <= 1'b1;
                    pal_kill_en[g] <= 1'b1;
                    secam_kill_en[g] <= 1'b1;
                    special_mode_en[g] <= 1'b0;
                    blue_stretch_en[g] <= 1'b0;
                    colour_sub[2*g +: 2] <= chan_misc_pkg::COLOUR_NONE;
                end else begin
                    ntsc_kill_en[g] <= eff[g][chan_misc_pkg::BIT_NKILL];
                    pal_kill_en[g] <= eff[g][chan_misc_pkg::BIT_PKILL];
                    secam_kill_en[g] <= eff[g][chan_misc_pkg::BIT_SKILL];
                    special_mode_en[g] <= eff[g][chan_misc_pkg::BIT_SPECIAL];
                    blue_stretch_en[g] <= eff[g][chan_misc_pkg::BIT_BSTRETCH];
                    colour_sub[2*g +: 2] <= colour_of(eff[g], video_loss[g]);
                end
            end
        end
    endgenerate

    force_wins_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (override_sel && chan_q[2][chan_misc_pkg::BIT_FORCE]) |=> colour_sub[5:4] != 2'h0)
        else $error("forced colour missing on channel 3");
    loss_sub_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (eff[1][chan_misc_pkg::BIT_LOSS] && video_loss[1]) |=> colour_sub[3:2] != 2'h0)
        else $error("loss substitution missing on channel 2");
    no_sub_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!eff[0][chan_misc_pkg::BIT_FORCE] && !eff[0][chan_misc_pkg::BIT_LOSS])
        |=> colour_sub[1:0] == 2'h0)
        else $error("unexpected colour on channel 1");
    blue_pick_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (eff[3][chan_misc_pkg::BIT_FORCE] && eff[3][chan_misc_pkg::BIT_COLOUR])
        |=> colour_sub[7:6] == 2'h2)
        else $error("blue not chosen on channel 4");
    shared_all_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !override_sel |=> ntsc_kill_en[3] == $past(shared_q[7]))
        else $error("shared byte not applied to channel 4");
    ch3_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (reg_wr && reg_addr == 8'h5E) |=> chan_q[2] == $past(reg_wdata))
        else $error("channel 3 byte not written");
    ch4_apply_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        override_sel |=> blue_stretch_en[3] == $past(chan_q[3][0]))
        else $error("channel 4 byte not applied");
    pal_kill_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        1'b1 |=> pal_kill_en[2] == $past(eff[2][6]))
        else $error("pal killer enable wrong");
    cov_loss_c: cover property (@(posedge clk_sys) eff[1][2] && video_loss[1]);
    cov_override_c: cover property (@(posedge clk_sys) $rose(override_sel));
    cov_force_c: cover property (@(posedge clk_sys) colour_sub[5:4] == 2'h2);
endmodule : chan_misc_ctrl

// ===== chan_misc_ctrl_bench.sv
// self-checking bench for the per-channel output control bytes
// assumes chan_misc_ctrl with outputs settled two edges after a write
`timescale 1ns/100ps
module chan_misc_ctrl_bench;
    logic clk_sys;
    logic rst_n;
    logic reg_wr;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, colour_sub;
    logic [3:0] video_loss, ntsc_kill_en, pal_kill_en, secam_kill_en;
    logic [3:0] special_mode_en, blue_stretch_en;
    int fail_count = 0;
    int num_checks = 0;
    // channel index, control byte, loss vector, expected colour
    typedef struct {int ch; logic [7:0] d; logic [3:0] loss; logic [1:0] col;} row_t;
    row_t rows[8] = '{'{1, 8'h00, 4'h0, 2'h0}, '{2, 8'h0A, 4'h0, 2'h2},
        '{3, 8'h04, 4'h8, 2'h1}, '{3, 8'h04, 4'h7, 2'h0}, '{2, 8'h0E, 4'h4, 2'h2},
        '{2, 8'h08, 4'h4, 2'h1}, '{1, 8'h96, 4'h2, 2'h2}, '{2, 8'h71, 4'h0, 2'h0}};
    chan_misc_ctrl dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .video_loss(video_loss), .ntsc_kill_en(ntsc_kill_en), .pal_kill_en(pal_kill_en),
        .secam_kill_en(secam_kill_en), .special_mode_en(special_mode_en),
        .blue_stretch_en(blue_stretch_en), .colour_sub(colour_sub));
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // one channel's controls packed as {0, kill x3, special, stretch, colour}
    function automatic logic [7:0] act(int i);
        return {1'b0, ntsc_kill_en[i], pal_kill_en[i], secam_kill_en[i],
            special_mode_en[i], blue_stretch_en[i], colour_sub[2*i+:2]};
    endfunction : act
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // entered at a falling edge; returns after the outputs have taken the byte
    task automatic wr(logic [7:0] a, logic [7:0] d, logic [3:0] l);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        video_loss = l;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        @(negedge clk_sys);
    endtask : wr
    task automatic stop_test;
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test
    initial begin
        #(1000 * 100);
        fail_count++;
        stop_test();
    end
    initial begin
        reg_wr = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        video_loss = 4'h0;
        rst_n = 1'b0;
        repeat (12) @(negedge clk_sys);
        rst_n = 1'b1;
        for (int i = 0; i < 4; i++) chk("reset", 8'h70, act(i));
        wr(8'h5C, 8'h20, 4'h0);
        foreach (rows[k]) begin
            wr(8'(8'h5C + rows[k].ch), rows[k].d, rows[k].loss);
            chk("chan", {1'b0, rows[k].d[7:4], rows[k].d[0], rows[k].col}, act(rows[k].ch));
        end
        chk("chan1", 8'h70, act(0));
        chk("chan4", 8'h00, act(3));
        // channel 2 keeps its byte while channel 3 was rewritten
        chk("chan2", 8'h48, act(1));
        wr(8'h96, 8'h0B, 4'h0);
        wr(8'h5C, 8'h00, 4'h0);
        for (int i = 0; i < 4; i++) chk("shared", 8'h06, act(i));
        reg_addr = 8'h5E;
        @(negedge clk_sys);
        chk("read", 8'h71, reg_rdata);
        reg_addr = 8'h60;
        @(negedge clk_sys);
        chk("unmapped", 8'h00, reg_rdata);
        stop_test();
    end
endmodule : chan_misc_ctrl_bench

// ===== chan_misc_pkg.sv
// constants for the per-channel output control bytes of channels 2 to 4
// assumes an internal register port that presents byte offsets and write strobes
// Summary of operation
// - bit 7 enables NTSC noisy colour killer
// - bit 6 enables PAL noisy colour killer
// - bit 5 enables SECAM noisy colour killer
// - bit 4 selects special output mode
// - bit 3 forces fixed colour output
// - bit 2 substitutes fixed colour on loss
// - bit 1 picks blue, else black
// - bit 0 enables blue stretch
// - channel 3 byte applies under override
// - channel 4 byte applies under override
// - override off: shared byte drives all channels
package chan_misc_pkg;
    localparam logic [7:0] OFS_SHARED = 8'h96;
    localparam logic [7:0] OFS_OVERRIDE = 8'h5C;
    localparam logic [7:0] OFS_CHAN2 = 8'h5D;
    localparam logic [7:0] OFS_CHAN3 = 8'h5E;
    localparam logic [7:0] OFS_CHAN4 = 8'h5F;
    localparam int BIT_OVERRIDE = 5;
    localparam int BIT_NKILL = 7;
    localparam int BIT_PKILL = 6;
    localparam int BIT_SKILL = 5;
    localparam int BIT_SPECIAL = 4;
    localparam int BIT_FORCE = 3;
    localparam int BIT_LOSS = 2;
    localparam int BIT_COLOUR = 1;
    localparam int BIT_BSTRETCH = 0;
    localparam logic [7:0] RST_CTRL = 8'hE0;
    localparam logic [7:0] RST_OVERRIDE_REG = 8'h01;
    localparam logic [1:0] COLOUR_NONE = 2'h0;
    localparam logic [1:0] COLOUR_BLACK = 2'h1;
    localparam logic [1:0] COLOUR_BLUE = 2'h2;
endpackage : chan_misc_pkg
